// ===== plc_cfg_pkg.sv
// Package for the modem configuration word and transmit time-out supervisor.
// Assumes a single 200 MHz system clock drives every user of these constants.
package plc_cfg_pkg;

    // Layout of the 24-bit configuration word, most significant field first.
    typedef struct packed {
        logic       prefilter_en;   // Bit 23.
        logic       high_sens;      // Bit 22.
        logic       reserved_21;    // Bit 21.
        logic [3:0] unused_20_17;   // Bits 20:17.
        logic [1:0] mclk_sel;       // Bits 16:15.
        logic       async_mode;     // Bit 14.
        logic [1:0] detect_method;  // Bits 13:12.
        logic       zc_sync;        // Bit 11.
        logic [1:0] detect_time;    // Bits 10:9.
        logic [1:0] timeout_flag_sel;       // Bits 8:7.
        logic       watchdog_en;    // Bit 6.
        logic       deviation;      // Bit 5.
        logic [1:0] baud_sel;       // Bits 4:3.
        logic [2:0] freq_sel;       // Bits 2:0.
    } cfg_t;

    // Value after reset: every field at its default setting.
    localparam logic [23:0] CFG_RESET = 24'h1362d7;

    // Detection method codes.
    localparam logic [1:0] DET_CARRIER      = 2'h0;
    localparam logic [1:0] DET_CARRIER_COND = 2'h1;
    localparam logic [1:0] DET_PREAMBLE     = 2'h2;
    localparam logic [1:0] DET_PREAMB_COND  = 2'h3;

    // Master clock ratio codes.
    localparam logic [1:0] MCLK_DIV1 = 2'h0;
    localparam logic [1:0] MCLK_DIV2 = 2'h1;
    localparam logic [1:0] MCLK_DIV4 = 2'h2;

    // Time-out selection codes.
    localparam logic [1:0] TIMEOUT_FLAG_OFF   = 2'h0;
    localparam logic [1:0] TIMEOUT_FLAG_SHORT = 2'h1;
    localparam logic [1:0] TIMEOUT_FLAG_LONG  = 2'h2;

    // Times in their own units, and the clock rate.
    localparam int unsigned CLK_KHZ       = 200000;
    localparam int unsigned TIMEOUT_FLAG_SHORT_MS = 1000;
    localparam int unsigned TIMEOUT_FLAG_LONG_MS  = 3000;
    localparam int unsigned TIMEOUT_FLAG_HOLD_MS  = 125;

    // Cycle counts derived from the times.
    localparam int unsigned TIMEOUT_FLAG_SHORT_CYC = TIMEOUT_FLAG_SHORT_MS * CLK_KHZ;
    localparam int unsigned TIMEOUT_FLAG_LONG_CYC  = TIMEOUT_FLAG_LONG_MS * CLK_KHZ;
    localparam int unsigned TIMEOUT_FLAG_HOLD_CYC  = TIMEOUT_FLAG_HOLD_MS * CLK_KHZ;

    // Width of the time-out counters.
    localparam int unsigned TCNT_W = 30;

    // Supervisor states.
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_LOCK = 2'b10
    } timeout_flag_state_t;

endpackage

// ===== plc_modem_config_and_tx_timeout.sv
// Configuration word upper fields, receive output conditioning, band-occupied
// qualification, master clock divider and the transmit time-out supervisor.
// Assumes all inputs are synchronous to i_clk and the word is written whole
// through the parallel write strobe by the serial front end.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Code 00: carrier reported on indicator, receive clock and data pass freely.
// - Code 01: receive clock and data forced low without carrier.
// - Code 10, default: preamble reported, receive clock and data pass freely.
// - Code 11: preamble reported, outputs low until preamble found or on unlock.
// - Bit 14 selects synchronous (0) or asynchronous (1) interface, default asynchronous.
// - Bits 16:15 select master clock ratio full, half, quarter; default quarter.
// - Bit 22 selects normal (0) or high (1) sensitivity, default normal.
// - Bit 23 enables the receive pre-filter, default disabled.
// - Band-occupied output high while an in-band signal is seen.
// - Band-occupied is qualified by the internal carrier detect.
// - Enabled time-out forces receive after 1 s or 3 s of transmission.
// - Time-out flag goes high and stays high at least 125 ms.
// - During time-out only register access or reception are allowed.
// - Both selects low at reset enter the lock; host then selects receive.
// - Bits 8:7 set the time-out duration and enable.
module plc_modem_config_and_tx_timeout #(
    parameter int unsigned TIMEOUT_FLAG_SHORT_CYC = plc_cfg_pkg::TIMEOUT_FLAG_SHORT_CYC,
    parameter int unsigned TIMEOUT_FLAG_LONG_CYC  = plc_cfg_pkg::TIMEOUT_FLAG_LONG_CYC,
    parameter int unsigned TIMEOUT_FLAG_HOLD_CYC  = plc_cfg_pkg::TIMEOUT_FLAG_HOLD_CYC
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Configuration word access.
    input  wire logic        i_cfg_wr,
    input  wire logic [23:0] i_cfg_wdata,
    output logic      [23:0] o_cfg_word,
    // Host control pins.
    input  wire logic        i_direction_select,
    input  wire logic        i_reg_access_select,
    // Receive front end.
    input  wire logic        i_carrier_raw,
    input  wire logic        i_preamble_found,
    input  wire logic        i_pll_locked,
    input  wire logic        i_inband_detect,
    input  wire logic        i_rx_bit_clock_raw,
    input  wire logic        i_rx_data_raw,
    // Receive outputs to host.
    output logic             o_carrier_detect_indicator_n,
    output logic             o_rx_tx_bit_clock,
    output logic             o_rx_data,
    output logic             o_band_occupied,
    // Time-out and transmit control.
    output logic             o_timeout_flag,
    output logic             o_tx_enable,
    // Settings to the analog and interface blocks.
    output logic             o_sync_mode,
    output logic             o_high_sensitivity,
    output logic             o_prefilter_enable,
    output logic             o_mclk
);

    plc_cfg_pkg::cfg_t           cfg_q;
    plc_cfg_pkg::timeout_flag_state_t    state_q;
    logic [plc_cfg_pkg::TCNT_W-1:0] tx_cnt_q;
    logic [plc_cfg_pkg::TCNT_W-1:0] hold_cnt_q;
    logic [plc_cfg_pkg::TCNT_W-1:0] tx_limit;
    logic                        timeout_flag_en;
    logic                        tx_expired;
    logic                        hold_done;
    logic                        rst_prev_q;
    logic                        strap_lock;
    logic                        rx_gate;
    logic                        detect_src;
    logic [1:0]                  div_cnt_q;
    logic [1:0]                  mclk_sel_q;
    logic [1:0]                  div_last;

    // Configuration word storage; bits 21:17 are kept as written since the
    // host is trusted to write their defaults back.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_q <= plc_cfg_pkg::cfg_t'(plc_cfg_pkg::CFG_RESET);
        end else if (i_cfg_wr) begin
            cfg_q <= plc_cfg_pkg::cfg_t'(i_cfg_wdata);
        end
    end

    // Read-back and static settings straight from flops.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cfg_word         <= plc_cfg_pkg::CFG_RESET;
            o_sync_mode        <= 1'b0;
            o_high_sensitivity <= 1'b0;
            o_prefilter_enable <= 1'b0;
        end else begin
            o_cfg_word         <= cfg_q;
            o_sync_mode        <= ~cfg_q.async_mode;
            o_high_sensitivity <= cfg_q.high_sens;
            o_prefilter_enable <= cfg_q.prefilter_en;
        end
    end

    // Choose what the indicator reports and when receive outputs are gated.
    always_comb begin
        detect_src = cfg_q.detect_method[1] ? i_preamble_found : i_carrier_raw;
        unique case (cfg_q.detect_method)
            plc_cfg_pkg::DET_CARRIER:      rx_gate = 1'b1;
            plc_cfg_pkg::DET_CARRIER_COND: rx_gate = i_carrier_raw;
            plc_cfg_pkg::DET_PREAMBLE:     rx_gate = 1'b1;
            plc_cfg_pkg::DET_PREAMB_COND:  rx_gate = i_preamble_found & i_pll_locked;
        endcase
    end

    // Receive outputs; the indicator is low while something is detected.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_carrier_detect_indicator_n <= 1'b1;
            o_rx_tx_bit_clock            <= 1'b0;
            o_rx_data                    <= 1'b0;
        end else begin
            o_carrier_detect_indicator_n <= ~detect_src;
            o_rx_tx_bit_clock            <= i_rx_bit_clock_raw & rx_gate;
            o_rx_data                    <= i_rx_data_raw & rx_gate;
        end
    end

    // Band-occupied is masked by carrier detect so noise alone cannot raise it.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_band_occupied <= 1'b0;
        end else begin
            o_band_occupied <= i_inband_detect & i_carrier_raw;
        end
    end

    // Master clock divider. A new ratio is taken only when the counter wraps
    // with the output high, so no short or stretched half period is ever emitted.
    always_comb begin
        unique case (mclk_sel_q)
            plc_cfg_pkg::MCLK_DIV1: div_last = 2'h0;
            plc_cfg_pkg::MCLK_DIV2: div_last = 2'h1;
            default:                div_last = 2'h3;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_cnt_q  <= 2'h0;
            o_mclk     <= 1'b0;
            mclk_sel_q <= plc_cfg_pkg::MCLK_DIV4;
        end else if (div_cnt_q == div_last) begin
            div_cnt_q <= 2'h0;
            o_mclk    <= ~o_mclk;
            // Code 11 is unused; hold the previous ratio rather than guess.
            if (o_mclk && cfg_q.mclk_sel != 2'h3) begin
                mclk_sel_q <= cfg_q.mclk_sel;
            end
        end else begin
            div_cnt_q <= div_cnt_q + 2'h1;
        end
    end

    // Time-out enable and limit from bits 8:7; code 11 leaves it disabled.
    always_comb begin
        timeout_flag_en    = (cfg_q.timeout_flag_sel == plc_cfg_pkg::TIMEOUT_FLAG_SHORT) ||
                     (cfg_q.timeout_flag_sel == plc_cfg_pkg::TIMEOUT_FLAG_LONG);
        tx_limit   = (cfg_q.timeout_flag_sel == plc_cfg_pkg::TIMEOUT_FLAG_LONG) ?
                     plc_cfg_pkg::TCNT_W'(TIMEOUT_FLAG_LONG_CYC - 1) :
                     plc_cfg_pkg::TCNT_W'(TIMEOUT_FLAG_SHORT_CYC - 1);
        tx_expired = timeout_flag_en && (tx_cnt_q == tx_limit);
        hold_done  = (hold_cnt_q == plc_cfg_pkg::TCNT_W'(TIMEOUT_FLAG_HOLD_CYC - 1));
        strap_lock = rst_prev_q && !i_direction_select && !i_reg_access_select;
    end

    // The selects are sampled in the first cycle after reset release, which
    // keeps the reset branch free of port values.
    always_ff @(posedge i_clk) begin
        rst_prev_q <= i_rst;
    end

    // Transmission time counter: runs only during transmit in the run state.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_direction_select || !timeout_flag_en || state_q != plc_cfg_pkg::ST_RUN) begin
            tx_cnt_q <= '0;
        end else if (!tx_expired) begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
        end
    end

    // Lock hold counter: saturates once the minimum flag time has elapsed.
    always_ff @(posedge i_clk) begin
        if (i_rst || state_q != plc_cfg_pkg::ST_LOCK) begin
            hold_cnt_q <= '0;
        end else if (!hold_done) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
        end
    end

    // Supervisor: lock on expiry or on the reset strap, and release only after
    // the hold time with receive requested.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= plc_cfg_pkg::ST_RUN;
        end else begin
            unique case (state_q)
                plc_cfg_pkg::ST_RUN: begin
                    if (tx_expired || strap_lock) begin
                        state_q <= plc_cfg_pkg::ST_LOCK;
                    end
                end
                plc_cfg_pkg::ST_LOCK: begin
                    if (hold_done && i_direction_select) begin
                        state_q <= plc_cfg_pkg::ST_RUN;
                    end
                end
                default: state_q <= plc_cfg_pkg::ST_RUN;
            endcase
        end
    end

    // Flag follows the state one cycle later; transmit permission drops on the same edge that enters the lock.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_timeout_flag <= 1'b0;
            o_tx_enable    <= 1'b0;
        end else begin
            o_timeout_flag <= (state_q == plc_cfg_pkg::ST_LOCK);
            o_tx_enable    <= (state_q == plc_cfg_pkg::ST_RUN) &&
                              !i_direction_select && !tx_expired && !strap_lock;
        end
    end

endmodule

`default_nettype wire

// ===== plc_host_model.sv
// Host model: drives the direction and register-access pins and writes the word.
// Assumes the bench changes its requests at rising edges.
`timescale 1ns/1ps
`default_nettype none
module plc_host_model (
    input  wire logic        i_clk, i_rx, i_reg_sel, i_wr,
    input  wire logic [23:0] i_word,
    output logic             o_direction_select, o_reg_access_select, o_cfg_wr,
    output logic      [23:0] o_cfg_wdata
);
    // Start in receive, as the pull-up on the direction pin would leave it.
    initial {o_direction_select, o_reg_access_select, o_cfg_wr, o_cfg_wdata} = {3'h6, 24'h0};
    // Spare and reserved bits always go out at their defaults, whatever the bench asks.
    always @(posedge i_clk) begin
        o_direction_select <= i_rx;
        o_reg_access_select <= i_reg_sel;
        o_cfg_wr <= i_wr;
        o_cfg_wdata <= {i_word[23:22], 5'h09, i_word[16:0]};
    end
endmodule
`default_nettype wire

// ===== plc_cfg_properties.sv
// Checker for the configuration word, receive gating and time-out supervisor.
// Assumes it is bound into the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module plc_cfg_properties #(
    parameter int unsigned TIMEOUT_FLAG_SHORT_CYC = 40,
    parameter int unsigned TIMEOUT_FLAG_LONG_CYC  = 120,
    parameter int unsigned TIMEOUT_FLAG_HOLD_CYC  = 10
) (
    input wire logic        i_clk, i_rst, i_direction_select, i_carrier_raw,
    input wire logic        i_preamble_found, i_pll_locked, i_inband_detect,
    input wire logic [23:0] o_cfg_word,
    input wire logic        o_carrier_detect_indicator_n, o_rx_tx_bit_clock, o_rx_data, o_band_occupied,
    input wire logic        o_timeout_flag, o_tx_enable, o_sync_mode, o_high_sensitivity, o_prefilter_enable
);
    int unsigned hold_q;
    int unsigned tx_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Run lengths of the flag and of transmit permission; a flag cut short or a transmission that never ends shows here.
    always_ff @(posedge i_clk) begin
        hold_q <= (i_rst || !o_timeout_flag) ? 0 : hold_q + 1;
    end
    always_ff @(posedge i_clk) begin
        tx_q <= (i_rst || !o_tx_enable) ? 0 : tx_q + 1;
    end
    a_band_qualified: assert property (
        !$past(i_rst) |-> o_band_occupied == ($past(i_inband_detect) && $past(i_carrier_raw)))
        else $error("band output differs from inband and carrier");
    a_detect_report: assert property (
        !$past(i_rst) && $stable(o_cfg_word) |-> o_carrier_detect_indicator_n ==
        !(o_cfg_word[13] ? $past(i_preamble_found) : $past(i_carrier_raw)))
        else $error("detect indicator wrong");
    a_carrier_gate: assert property (
        $stable(o_cfg_word) && o_cfg_word[13:12] == 2'h1 && (o_rx_data || o_rx_tx_bit_clock) |-> $past(i_carrier_raw))
        else $error("receive outputs active without carrier");
    a_preamble_gate: assert property (
        $stable(o_cfg_word) && o_cfg_word[13:12] == 2'h3 && (o_rx_data || o_rx_tx_bit_clock)
        |-> $past(i_preamble_found) && $past(i_pll_locked))
        else $error("receive outputs active without preamble or lock");
    a_static_fields: assert property (
        {o_sync_mode, o_high_sensitivity, o_prefilter_enable} == {!o_cfg_word[14], o_cfg_word[22], o_cfg_word[23]})
        else $error("static settings differ from word");
    a_tx_refused: assert property (o_tx_enable |-> !$past(i_direction_select))
        else $error("transmit allowed while receive selected");
    a_flag_hold: assert property ($fell(o_timeout_flag) |-> hold_q >= TIMEOUT_FLAG_HOLD_CYC)
        else $error("time-out flag held too briefly");
    a_tx_bound: assert property (
        o_cfg_word[8] ^ o_cfg_word[7] |-> tx_q <= (o_cfg_word[8] ? TIMEOUT_FLAG_LONG_CYC : TIMEOUT_FLAG_SHORT_CYC) + 2)
        else $error("transmission outlived its time-out");
endmodule
`default_nettype wire

// ===== tb_plc_modem_config_and_tx_timeout.sv
// Bench for the configuration word and time-out supervisor, with a host model on the control pins.
// Assumes package, design, checker and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
bind plc_modem_config_and_tx_timeout plc_cfg_properties #(.TIMEOUT_FLAG_SHORT_CYC(TIMEOUT_FLAG_SHORT_CYC),
    .TIMEOUT_FLAG_LONG_CYC(TIMEOUT_FLAG_LONG_CYC), .TIMEOUT_FLAG_HOLD_CYC(TIMEOUT_FLAG_HOLD_CYC)) i_plc_cfg_properties (.*);
module tb_plc_modem_config_and_tx_timeout;
    localparam int SC = 40;
    localparam int LC = 120;
    localparam int HC = 10;
    logic clk, rst, rx, rsel, wr, car, pre, pll, inb, rclk, rdat, p, g;
    logic [23:0] word, w;
    int miscompares, tests_run, n;
    wire logic dir, regs, wrs, ind_n, bclk, dout, band, flag, txen, syncm, hs, pf, mclk;
    wire logic [23:0] wdat, cfg;
    plc_host_model i_plc_host_model (.i_clk(clk), .i_rx(rx), .i_reg_sel(rsel), .i_wr(wr), .i_word(word),
        .o_direction_select(dir), .o_reg_access_select(regs), .o_cfg_wr(wrs), .o_cfg_wdata(wdat));
    plc_modem_config_and_tx_timeout #(.TIMEOUT_FLAG_SHORT_CYC(SC), .TIMEOUT_FLAG_LONG_CYC(LC), .TIMEOUT_FLAG_HOLD_CYC(HC))
    i_plc_modem_config_and_tx_timeout (.i_clk(clk), .i_rst(rst), .i_cfg_wr(wrs), .i_cfg_wdata(wdat),
        .o_cfg_word(cfg), .i_direction_select(dir), .i_reg_access_select(regs), .i_carrier_raw(car),
        .i_preamble_found(pre), .i_pll_locked(pll), .i_inband_detect(inb), .i_rx_bit_clock_raw(rclk),
        .i_rx_data_raw(rdat), .o_carrier_detect_indicator_n(ind_n), .o_rx_tx_bit_clock(bclk), .o_rx_data(dout),
        .o_band_occupied(band), .o_timeout_flag(flag), .o_tx_enable(txen), .o_sync_mode(syncm),
        .o_high_sensitivity(hs), .o_prefilter_enable(pf), .o_mclk(mclk));
    // Clock at 200 MHz.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] v);
        tests_run++;
        if (v !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // Reset with both selects at d; low on both straps the device into the lock.
    task automatic do_reset(input logic d);
        @(posedge clk);
        rst <= 1'b1; rx <= d; rsel <= d;
        cyc(16);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    // The host model adds a cycle, so the word settles a few cycles after the strobe.
    task automatic wr_cfg(input logic [23:0] v);
        @(posedge clk);
        wr <= 1'b1; word <= v;
        @(posedge clk);
        wr <= 1'b0;
        cyc(4);
    endtask
    task automatic t_static();
        w = plc_cfg_pkg::CFG_RESET;
        w[23:14] = 10'h3fa;
        wr_cfg(w);
        #1;
        cmp("cfg_word", {w[23:22], 5'h09, w[16:0]}, cfg);
        cmp("static_pins", 24'h7, 24'({syncm, hs, pf}));
    endtask
    // Counting rising edges over 32 cycles gives the ratio; the unused code keeps the last one.
    task automatic t_mclk();
        for (int c = 0; c < 4; c++) begin
            w = plc_cfg_pkg::CFG_RESET;
            w[16:15] = c[1:0];
            wr_cfg(w);
            cyc(20);
            #1;
            p = mclk;
            n = 0;
            repeat (32) begin
                @(posedge clk);
                #1;
                n += int'(mclk === 1'b1 && p === 1'b0);
                p = mclk;
            end
            cmp("mclk_rises", 24'(32 >> (c == 3 ? 3 : c + 1)), 24'(n));
        end
    endtask
    task automatic t_rx();
        for (int m = 0; m < 4; m++) begin
            w = plc_cfg_pkg::CFG_RESET;
            w[13:12] = m[1:0];
            wr_cfg(w);
            for (int i = 0; i < 16; i++) begin
                @(posedge clk);
                {inb, pll, pre, car} <= i[3:0];
                rdat <= ~i[0];
                @(posedge clk);
                #1;
                g = (m == 1) ? i[0] : (m == 3) ? (i[1] & i[2]) : 1'b1;
                cmp("rx_pins", 24'({~(m[1] ? i[1] : i[0]), g, g & ~i[0], i[3] & i[0]}),
                    24'({ind_n, bclk, dout, band}));
            end
        end
    endtask
    // Direction high must end the lock once the hold has run; lo is the least flag time left.
    task automatic release_lock(input int lo);
        @(posedge clk);
        rx <= 1'b1;
        n = 0;
        while (flag === 1'b1 && n < HC + 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp("unlock", 24'h1, 24'(n >= lo && n < HC + 8));
        if (n >= HC + 20) final_report();
    endtask
    // A short receive spell after pre_tx cycles of sending must restart the count.
    task automatic t_timeout_flag(input logic [1:0] sel, input int lim, input int pre_tx);
        w = plc_cfg_pkg::CFG_RESET;
        w[8:7] = sel;
        wr_cfg(w);
        if (pre_tx > 0) begin
            rx <= 1'b0;
            cyc(pre_tx);
            rx <= 1'b1;
            cyc(3);
        end
        rx <= 1'b0;
        n = 0;
        while (flag !== 1'b1 && n < lim + 9) begin
            @(posedge clk);
            #1;
            n++;
            if (n == 3) cmp("tx_allowed", 24'h1, 24'(txen));
        end
        cmp("lock_time", 24'h1, 24'(n > lim && n < lim + 6));
        if (n >= lim + 9) final_report();
        cyc(HC + 5);
        #1;
        cmp("lock_hold", 24'h2, 24'({flag, txen}));
        release_lock(1);
    endtask
    task automatic t_strap();
        do_reset(1'b0);
        cyc(2);
        #1;
        cmp("strap_lock", 24'h2, 24'({flag, txen}));
        cmp("reset_word", plc_cfg_pkg::CFG_RESET, cfg);
        cmp("reset_pins", 24'h0, 24'({syncm, hs, pf}));
        release_lock(HC - 4);
    endtask
    initial begin
        {rst, rx, rsel, wr, car, pre, pll, inb, rclk, rdat} = 10'h382;
        word = 24'h0;
        miscompares = 0;
        tests_run = 0;
        do_reset(1'b1);
        #1;
        cmp("reset_word", plc_cfg_pkg::CFG_RESET, cfg);
        t_static();
        t_mclk();
        t_rx();
        t_timeout_flag(plc_cfg_pkg::TIMEOUT_FLAG_SHORT, SC, 0);
        t_timeout_flag(plc_cfg_pkg::TIMEOUT_FLAG_LONG, LC, 0);
        t_timeout_flag(plc_cfg_pkg::TIMEOUT_FLAG_SHORT, SC, 30);
        t_strap();
        final_report();
    end
endmodule
`default_nettype wire
